// *** pkg/rivm_pkg.sv ***
// Package for the reset and interrupt vector map
package rivm_pkg;
    localparam int NUM_IRQ = 30;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 16;
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0002;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [15:0] VEC_LAST = 16'h003c;
    localparam logic [15:0] BOOT_RESET_ADDR_DEF = 16'hf800;
    localparam logic [5:0] CTRL_IO_ADDR = 6'h35;
    localparam logic [7:0] CTRL_MEM_ADDR = 8'h55;
    localparam int SEL_BIT = 1;
    localparam int UNLOCK_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic FUSE_PROGRAMMED = 1'b0;

    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic [15:0] addr;
    } rivm_dispatch_t;

    typedef struct packed {
        logic we;
        logic [7:0] data;
    } rivm_ctrl_wr_t;

    typedef enum logic [1:0] {
        UNL_IDLE = 2'b00,
        UNL_OPEN = 2'b01
    } rivm_unl_state_t;
endpackage

// *** hdl/rivm_prio_enc.sv ***
// Lowest-index-first priority encoder over pending requests
`timescale 1ns/10ps
module rivm_prio_enc #(
    parameter int N = 30,
    parameter int W = 5
) (
    input wire logic [N-1:0] req,
    output logic found,
    output logic [W-1:0] idx
);
    always_comb begin
        found = 1'b0;
        idx = '0;
        // Scan high to low so the lowest set bit wins last
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule

// *** hdl/rivm_vector_map.sv ***
// Reset and interrupt vector address map with relocatable table
//
// Summary of operation
// - Every reset cause shares vector 1 at address 0x0000.
// - External requests at 0x0002-0x0006, pin-change groups 0x0008-0x000E, watchdog 0x0010.
// - Timer vectors 0x0012-0x0024: timer2 A,B,ovf; timer1 cap,A,B,ovf; timer0 A,B,ovf.
// - Vectors 0x0026-0x003C: SPI, serial0 x3, comparator, converter, EEPROM, two-wire, store, serial1 x3.
// - Programmed boot-reset fuse starts execution at boot reset address after reset.
// - Select bit set adds boot section start to every interrupt vector address.
// - Fuse alone picks reset address; select bit alone picks vector base.
// - Select is bit 1 of control register at I/O 0x35, memory 0x55.
// - Select changes only within four cycles after unlock, with unlock written zero.
`timescale 1ns/10ps
module rivm_vector_map #(
    parameter int NUM_IRQ = rivm_pkg::NUM_IRQ,
    parameter logic [15:0] BOOT_RESET_ADDR = rivm_pkg::BOOT_RESET_ADDR_DEF
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic BOOT_RESET_FUSE,
    input wire logic CTRL_WE,
    input wire logic [5:0] CTRL_ADDR,
    input wire logic [7:0] CTRL_WDATA,
    output logic [7:0] CTRL_RDATA,
    input wire logic [NUM_IRQ-1:0] IRQ_PENDING,
    input wire logic ACK,
    output logic [15:0] RESET_VECTOR,
    output logic VECTOR_TABLE_SELECT,
    output logic IRQ_VALID,
    output logic [4:0] IRQ_INDEX,
    output logic [15:0] IRQ_ADDR
);
    logic sel_q;
    logic unlock_q;
    logic [2:0] unl_cnt_q;
    rivm_pkg::rivm_unl_state_t unl_state_q;
    rivm_pkg::rivm_ctrl_wr_t wr;
    rivm_pkg::rivm_dispatch_t disp_d;
    rivm_pkg::rivm_dispatch_t disp_q;
    logic [15:0] reset_vec_q;
    logic hit;
    logic found;
    logic [4:0] idx;

    // Only the control register address is decoded; other I/O writes pass by
    assign wr = '{we: CTRL_WE && (CTRL_ADDR == rivm_pkg::CTRL_IO_ADDR),
                  data: CTRL_WDATA};
    assign hit = wr.we;

    // Unlock window: open for four cycles after unlock written one
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            unl_state_q <= rivm_pkg::UNL_IDLE;
            unl_cnt_q <= 3'h0;
        end else if (hit && wr.data[rivm_pkg::UNLOCK_BIT]) begin
            // A fresh unlock restarts the count rather than stacking on it
            unl_state_q <= rivm_pkg::UNL_OPEN;
            unl_cnt_q <= rivm_pkg::UNLOCK_CYCLES;
        end else begin
            case (unl_state_q)
                rivm_pkg::UNL_OPEN: begin
                    if (hit || unl_cnt_q == 3'h1) begin
                        unl_state_q <= rivm_pkg::UNL_IDLE;
                        unl_cnt_q <= 3'h0;
                    end else begin
                        unl_cnt_q <= unl_cnt_q - 3'h1;
                    end
                end
                default: begin
                    unl_state_q <= rivm_pkg::UNL_IDLE;
                    unl_cnt_q <= 3'h0;
                end
            endcase
        end
    end

    assign unlock_q = (unl_state_q == rivm_pkg::UNL_OPEN);

    // Select moves only on the closing write of the unlock sequence
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sel_q <= rivm_pkg::CTRL_RESET[rivm_pkg::SEL_BIT];
        end else if (hit && unlock_q && !wr.data[rivm_pkg::UNLOCK_BIT]) begin
            sel_q <= wr.data[rivm_pkg::SEL_BIT];
        end
    end

    always_comb begin
        CTRL_RDATA = 8'h00;
        CTRL_RDATA[rivm_pkg::SEL_BIT] = sel_q;
        CTRL_RDATA[rivm_pkg::UNLOCK_BIT] = unlock_q;
    end

    // Fuse sampled while reset is held so fetch starts at the right place
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            if (BOOT_RESET_FUSE == rivm_pkg::FUSE_PROGRAMMED) begin
                reset_vec_q <= BOOT_RESET_ADDR;
            end else begin
                reset_vec_q <= rivm_pkg::RESET_ADDR;
            end
        end
    end

    // Enables are masked by the core, so every pending bit here is eligible
    rivm_prio_enc #(.N(NUM_IRQ), .W(rivm_pkg::IDX_W)) u_prio (
        .req(IRQ_PENDING),
        .found(found),
        .idx(idx)
    );

    always_comb begin
        logic [15:0] base;
        base = sel_q ? BOOT_RESET_ADDR : 16'h0000;
        disp_d.valid = found;
        disp_d.index = idx;
        // Table order fixed by index: step of two words from the first vector
        disp_d.addr = 16'(base + rivm_pkg::VEC_BASE
                      + 16'(rivm_pkg::VEC_STEP * 16'(idx)));
    end

    // Hold the offered vector stable until the core acknowledges it
    // A held offer keeps the base it was formed with, so move the table only while idle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            disp_q <= '0;
        end else if (!disp_q.valid || ACK) begin
            disp_q <= disp_d;
        end
    end

    assign RESET_VECTOR = reset_vec_q;
    assign VECTOR_TABLE_SELECT = sel_q;
    assign IRQ_VALID = disp_q.valid;
    assign IRQ_INDEX = disp_q.index;
    assign IRQ_ADDR = disp_q.addr;

    // Steps of a guarded select change and of a taken offer, shared by the checks below
    sequence s_unlock_wr;
        hit && wr.data[rivm_pkg::UNLOCK_BIT];
    endsequence

    sequence s_close_wr;
        hit && unlock_q && !wr.data[rivm_pkg::UNLOCK_BIT];
    endsequence

    sequence s_quiet_window;
        (!hit)[*4];
    endsequence

    sequence s_offer_taken;
        IRQ_VALID && ACK;
    endsequence

    // Checks: reset first, then the select guard, then the vector offer
    chk_reset_addr_fuse: assert property (@(posedge CLK)
        $fell(SYS_RST) |-> RESET_VECTOR ==
            ($past(BOOT_RESET_FUSE) ? rivm_pkg::RESET_ADDR : BOOT_RESET_ADDR))
        else $error("reset vector not chosen by fuse");

    chk_reset_clear: assert property (@(posedge CLK)
        $fell(SYS_RST) |-> !sel_q && !IRQ_VALID)
        else $error("select or offer not cleared by reset");

    chk_reset_vec_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> $stable(RESET_VECTOR))
        else $error("reset vector moved outside reset");

    chk_sel_locked: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(unlock_q) |-> $stable(sel_q))
        else $error("select changed outside unlock window");

    chk_unlock_open: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_unlock_wr |=> unlock_q && (unl_cnt_q == rivm_pkg::UNLOCK_CYCLES))
        else $error("unlock write did not open a full window");

    chk_window_len: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_unlock_wr ##1 s_quiet_window |=> !unlock_q)
        else $error("unlock window longer than four cycles");

    chk_sel_commit: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_close_wr |=> !unlock_q && (sel_q == $past(wr.data[rivm_pkg::SEL_BIT])))
        else $error("closing write did not commit select");

    chk_vec_first: assert property (@(posedge CLK) disable iff (SYS_RST)
        (IRQ_VALID && IRQ_INDEX == 5'h00 && !sel_q && !$past(sel_q))
            |-> IRQ_ADDR == rivm_pkg::VEC_BASE)
        else $error("first vector not at base");

    chk_vec_last: assert property (@(posedge CLK) disable iff (SYS_RST)
        (IRQ_VALID && IRQ_INDEX == 5'h1d && !sel_q && !$past(sel_q))
            |-> IRQ_ADDR == rivm_pkg::VEC_LAST)
        else $error("last vector address wrong");

    chk_boot_offset: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!ACK && !$past(ACK) && $past(IRQ_VALID) && sel_q && $past(sel_q)) |->
            IRQ_ADDR >= BOOT_RESET_ADDR + rivm_pkg::VEC_BASE)
        else $error("vectors not relocated to boot section");

    chk_boot_first: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!$past(SYS_RST) && $past(!IRQ_VALID || ACK) && $past(IRQ_PENDING[0]) && $past(sel_q))
            |-> IRQ_ADDR == 16'(BOOT_RESET_ADDR + rivm_pkg::VEC_BASE))
        else $error("first vector not relocated to boot section");

    chk_lowest_wins: assert property (@(posedge CLK) disable iff (SYS_RST)
        ($past(!IRQ_VALID || ACK) && $past(IRQ_PENDING[0])) |-> IRQ_INDEX == 5'h00)
        else $error("lowest pending request not dispatched");

    chk_idle_no_req: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!$past(SYS_RST) && $past(!IRQ_VALID || ACK) && ($past(IRQ_PENDING) == '0))
            |-> !IRQ_VALID)
        else $error("offer raised with nothing pending");

    chk_take_reload: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_offer_taken ##0 (IRQ_PENDING == '0) |=> !IRQ_VALID)
        else $error("offer kept after acknowledge with nothing pending");

    chk_hold_stable: assert property (@(posedge CLK) disable iff (SYS_RST)
        (IRQ_VALID && !ACK) |=> $stable(IRQ_ADDR) && IRQ_VALID)
        else $error("offered vector changed before acknowledge");
endmodule

// *** test/rivm_core_model.sv ***
// Core dispatch model that takes offered vectors
`timescale 1ns/10ps
module rivm_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic irq_valid,
    input wire logic [4:0] irq_index,
    input wire logic [15:0] irq_addr,
    output logic ack_q,
    output logic [4:0] index_q,
    output logic [15:0] addr_q,
    output logic [7:0] taken_q
);
    logic [1:0] wait_q;
    // Slow mode leaves the offer standing three cycles longer than fast mode before taking it
    always_ff @(posedge clk) begin
        if (rst || !irq_valid || ack_q) begin
            ack_q <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            ack_q <= (wait_q == (slow ? 2'h3 : 2'h0));
            wait_q <= wait_q + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            taken_q <= 8'h00;
        end else if (irq_valid && ack_q) begin
            taken_q <= taken_q + 8'h01;
            index_q <= irq_index;
            addr_q <= irq_addr;
        end
    end
endmodule

// *** test/test_rivm_vector_map.sv ***
// Self-checking bench for the vector map
`timescale 1ns/10ps
module test_rivm_vector_map;
    localparam logic [15:0] BOOT = 16'h1f00;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b1;
    logic we = 1'b0;
    logic slow = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [29:0] pend = 30'h0;
    logic [7:0] rdata;
    logic [15:0] rvec, iaddr, gaddr;
    logic sel, valid, ack;
    logic [4:0] idx, gidx;
    logic [7:0] taken;
    int miscompares = 0;
    int tests_run = 0;
    initial forever #4 clk = ~clk;
    rivm_vector_map #(.BOOT_RESET_ADDR(BOOT)) u_rivm_vector_map (.CLK(clk), .SYS_RST(rst),
        .BOOT_RESET_FUSE(fuse), .CTRL_WE(we), .CTRL_ADDR(addr), .CTRL_WDATA(wdata),
        .CTRL_RDATA(rdata), .IRQ_PENDING(pend), .ACK(ack), .RESET_VECTOR(rvec),
        .VECTOR_TABLE_SELECT(sel), .IRQ_VALID(valid), .IRQ_INDEX(idx), .IRQ_ADDR(iaddr));
    rivm_core_model u_rivm_core_model (.clk(clk), .rst(rst), .slow(slow), .irq_valid(valid),
        .irq_index(idx), .irq_addr(iaddr), .ack_q(ack), .index_q(gidx), .addr_q(gaddr),
        .taken_q(taken));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic f);
        @(negedge clk);
        fuse = f;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic take(input logic [29:0] p, input logic [4:0] ei, input logic [15:0] ea);
        logic [7:0] n;
        n = taken;
        @(negedge clk);
        pend = p;
        for (int k = 0; k < 20 && taken == n; k++) @(negedge clk);
        check(16'(taken != n), 16'h1);
        check(16'(gidx), 16'(ei));
        check(gaddr, ea);
        pend = 30'h0;
        repeat (6) @(negedge clk);
        check(16'(valid), 16'h0);
    endtask
    task automatic t_map(input logic [15:0] base);
        for (int i = 0; i < 30; i++) take(30'h1 << i, 5'(i), base + 16'h2 + 16'(2 * i));
        $display("map test done");
    endtask
    task automatic t_sel();
        wr(6'h35, 8'h02);
        check(16'(sel), 16'h0);
        wr(6'h34, 8'h01);
        wr(6'h35, 8'h02);
        check(16'(sel), 16'h0);
        wr(6'h35, 8'h01);
        check(16'(rdata[0]), 16'h1);
        wr(6'h35, 8'h03);
        check(16'(sel), 16'h0);
        repeat (6) @(negedge clk);
        check(16'(rdata[0]), 16'h0);
        wr(6'h35, 8'h02);
        check(16'(sel), 16'h0);
        wr(6'h35, 8'h01);
        wr(6'h35, 8'h02);
        check(16'(sel), 16'h1);
        check(16'(rdata[1]), 16'h1);
        $display("select test done");
    endtask
    initial begin
        do_reset(1'b0);
        check(rvec, BOOT);
        do_reset(1'b1);
        check(rvec, 16'h0000);
        $display("reset test done");
        t_map(16'h0000);
        t_sel();
        t_map(BOOT);
        slow = 1'b1;
        take(30'h20100008, 5'h3, BOOT + 16'h8);
        $display("priority test done");
        do_reset(1'b1);
        check(16'(sel), 16'h0);
        give_verdict();
    end
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
